// ---- rtl/qdac_map.svh ----
// constants for the quad converter serial load logic
`ifndef QDAC_MAP_SVH
`define QDAC_MAP_SVH

`define QDAC_WORD_W     12
`define QDAC_SAC_BIT    11
`define QDAC_SDC_BIT    10
`define QDAC_ADDR_HI    9
`define QDAC_ADDR_LO    8
`define QDAC_CODE_HI    7
`define QDAC_CODE_W     8
`define QDAC_NUM_CH     4
`define QDAC_ZERO_CODE  8'h00
`define QDAC_FIFO_DEPTH 16
`define QDAC_PIN_W      6
`define QDAC_PIN_RST    6'h32
`define QDAC_PIN_SCLK   0
`define QDAC_PIN_CS_N   1
`define QDAC_PIN_DATA   2
`define QDAC_PIN_FLOAT  3
`define QDAC_PIN_LOAD_N 4
`define QDAC_PIN_CLR_N  5

`endif

// ---- rtl/qdac_pkg.sv ----
// types shared by the quad converter serial load logic
package qdac_pkg;
  typedef logic [7:0]  qdac_code_type;
  typedef logic [1:0]  qdac_chan_type;
  typedef logic [11:0] qdac_word_type;
endpackage

// ---- rtl/qdac_fifo.sv ----
// word fifo between serial capture and input register update
`timescale 1ns/1ps
module qdac_fifo
  import qdac_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop)
      begin
        count_ff <= count_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/qdac_top.sv ----
// serial load logic of a quad 8-bit converter
// Summary of operation
// - each rising serial clock edge with chip select low shifts the data pin into the shift register
// - words travel top bit first and fill the shift register in that order
// - with chip select high, serial clock edges are ignored, register held
// - chip select rising copies the payload to the addressed input register
// - chip select has no influence on the load strobe path
// - load strobe low copies all four input registers to the outputs together
// - output registers follow input registers while load low, latch when high
// - clear low forces input and output registers to zero without any clock
// - clear leaves the serial shift register untouched
// - a floating data pin requests hardware shutdown
// - during hardware shutdown every channel output is open circuit
// - entering or leaving shutdown never alters the stored output codes
// - a word is 12 bits: all-off, selected-off, two address, eight data
// - only the last 12 bits before chip select rises are decoded
// - address 00,01,10,11 select the first to the fourth channel
// - top bit low stops all, next bit low stops addressed; data still loads
`timescale 1ns/1ps
`include "qdac_map.svh"
module qdac_top
  import qdac_pkg::*;
#(
  parameter int FIFO_DEPTH = `QDAC_FIFO_DEPTH
)
(
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  input  wire logic  serial_clk_i,
  input  wire logic  chip_sel_n_i,
  input  wire logic  serial_in_or_float_off_i,
  input  wire logic  serial_in_float_i,
  input  wire logic  load_outputs_n_i,
  input  wire logic  clear_all_n_i,
  output logic [7:0] channel_output_first_o,
  output logic [7:0] channel_output_second_o,
  output logic [7:0] channel_output_third_o,
  output logic [7:0] channel_output_fourth_o,
  output logic [3:0] chan_open_o,
  output logic       hw_power_down_o,
  output logic       word_ready_o
);
  // pin synchronisers
  logic [`QDAC_PIN_W-1:0] pin_raw;
  logic [`QDAC_PIN_W-1:0] pin_s1_ff;
  logic [`QDAC_PIN_W-1:0] pin_s2_ff;
  logic                   sclk_d_ff;
  logic                   cs_d_ff;
  logic                   sclk_rise;
  logic                   cs_rise;
  logic                   cs_n_s;
  logic                   data_s;
  logic                   load_n_s;
  logic                   clr_n_s;
  logic                   float_s;

  // serial and storage state
  qdac_word_type          sr_ff;
  qdac_code_type          in_ff  [`QDAC_NUM_CH];
  qdac_code_type          dac_ff [`QDAC_NUM_CH];
  logic [3:0]             sw_sd_ff;
  logic                   hw_pd_ff;
  logic [3:0]             chan_open_ff;
  logic                   word_ready_ff;
  logic                   clr_rst;

  // fifo handshake
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  qdac_word_type          fifo_out_data;
  logic                   pop;
  qdac_chan_type          pop_chan;
  qdac_code_type          pop_code;
  logic                   pop_sac_n;
  logic                   pop_sdc_n;

  assign pin_raw[`QDAC_PIN_SCLK]   = serial_clk_i;
  assign pin_raw[`QDAC_PIN_CS_N]   = chip_sel_n_i;
  assign pin_raw[`QDAC_PIN_DATA]   = serial_in_or_float_off_i;
  assign pin_raw[`QDAC_PIN_FLOAT]  = serial_in_float_i;
  assign pin_raw[`QDAC_PIN_LOAD_N] = load_outputs_n_i;
  assign pin_raw[`QDAC_PIN_CLR_N]  = clear_all_n_i;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_ff <= `QDAC_PIN_RST;
      pin_s2_ff <= `QDAC_PIN_RST;
    end
    else
    begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign cs_n_s   = pin_s2_ff[`QDAC_PIN_CS_N];
  assign data_s   = pin_s2_ff[`QDAC_PIN_DATA];
  assign load_n_s = pin_s2_ff[`QDAC_PIN_LOAD_N];
  assign clr_n_s  = pin_s2_ff[`QDAC_PIN_CLR_N];
  assign float_s  = pin_s2_ff[`QDAC_PIN_FLOAT];

  // edge finders look only at the second stage
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= pin_s2_ff[`QDAC_PIN_SCLK];
      cs_d_ff   <= cs_n_s;
    end
  end

  assign sclk_rise = pin_s2_ff[`QDAC_PIN_SCLK] && !sclk_d_ff;
  assign cs_rise   = cs_n_s && !cs_d_ff;

  // shift register; clear is not in its reset path
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sr_ff <= '0;
    end
    else if (sclk_rise && !cs_n_s)
    begin
      // older bits fall off the top so only the last 12 remain
      sr_ff <= {sr_ff[`QDAC_WORD_W-2:0], data_s};
    end
  end

  // words wait here so a burst of writes survives a held clear
  qdac_fifo #(
    .WIDTH (`QDAC_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (cs_rise),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sr_ff),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // draining stalls once the synchronised clear is low, two cycles after clear acts, so words popped in between are lost into it
  assign fifo_out_ready = clr_n_s;
  assign pop            = fifo_out_valid && fifo_out_ready;
  assign pop_sac_n      = fifo_out_data[`QDAC_SAC_BIT];
  assign pop_sdc_n      = fifo_out_data[`QDAC_SDC_BIT];
  assign pop_chan       = fifo_out_data[`QDAC_ADDR_HI:`QDAC_ADDR_LO];
  assign pop_code       = fifo_out_data[`QDAC_CODE_HI:0];

  // clear acts asynchronously; both stages only ever take the zero code
  assign clr_rst = rst_i || !clear_all_n_i;

  // input registers update whole in one edge, so a transparent output
  // register can never see a half-written code
  genvar ch;
  generate
    for (ch = 0; ch < `QDAC_NUM_CH; ch++)
    begin : g_chan
      always_ff @(posedge ref_clk_i or posedge clr_rst)
      begin
        if (clr_rst)
        begin
          in_ff[ch] <= `QDAC_ZERO_CODE;
        end
        else if (pop && (pop_chan == qdac_chan_type'(ch)))
        begin
          in_ff[ch] <= pop_code;
        end
      end

      always_ff @(posedge ref_clk_i or posedge clr_rst)
      begin
        if (clr_rst)
        begin
          dac_ff[ch] <= `QDAC_ZERO_CODE;
        end
        else if (!load_n_s)
        begin
          dac_ff[ch] <= in_ff[ch];
        end
      end
    end
  endgenerate

  // software shutdown; a word with both stop bits high wakes its channel
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sw_sd_ff <= '0;
    end
    else if (pop)
    begin
      if (!pop_sac_n)
      begin
        sw_sd_ff <= '1;
      end
      else
      begin
        sw_sd_ff[pop_chan] <= !pop_sdc_n;
      end
    end
  end

  // shutdown only gates the outputs; stored codes stay put
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hw_pd_ff     <= 1'b0;
      chan_open_ff <= '0;
    end
    else
    begin
      hw_pd_ff     <= float_s;
      chan_open_ff <= {`QDAC_NUM_CH{hw_pd_ff}} | sw_sd_ff;
    end
  end

  // a host sending faster than the fifo drains sees this drop
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_ready_ff <= 1'b1;
    end
    else
    begin
      word_ready_ff <= fifo_in_ready;
    end
  end

  assign channel_output_first_o  = dac_ff[0];
  assign channel_output_second_o = dac_ff[1];
  assign channel_output_third_o  = dac_ff[2];
  assign channel_output_fourth_o = dac_ff[3];
  assign chan_open_o             = chan_open_ff;
  assign hw_power_down_o         = hw_pd_ff;
  assign word_ready_o            = word_ready_ff;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_shift_edge;
    sclk_rise && !cs_n_s;
  endsequence

  sequence s_cs_rise;
    !cs_n_s ##1 cs_n_s;
  endsequence

  a_shift_msb_first: assert property (
    s_shift_edge |=> sr_ff == {$past(sr_ff[10:0]), $past(data_s)})
    else $error("shift register did not take the data bit at the bottom");

  a_cs_high_hold: assert property (
    cs_n_s |=> $stable(sr_ff))
    else $error("shift register moved while chip select was high");

  a_cs_rise_push: assert property (
    s_cs_rise ##0 (fifo_in_ready && clr_n_s && !fifo_out_valid)
      ##1 fifo_out_valid |-> ##[0:2] pop)
    else $error("word taken at chip select rise was not applied");

  a_addr_decode: assert property (
    pop && clear_all_n_i ##1 clear_all_n_i
      |-> in_ff[$past(pop_chan)] == $past(pop_code))
    else $error("input register of the addressed channel not loaded");

  a_load_transparent: assert property (
    !load_n_s && clear_all_n_i ##1 clear_all_n_i
      |-> dac_ff[0] == $past(in_ff[0]) && dac_ff[3] == $past(in_ff[3])
      && dac_ff[1] == $past(in_ff[1]) && dac_ff[2] == $past(in_ff[2]))
    else $error("output register did not follow input register");

  a_load_latched: assert property (
    load_n_s && clear_all_n_i ##1 clear_all_n_i
      |-> $stable(dac_ff[1]) && $stable(dac_ff[2])
      && $stable(dac_ff[0]) && $stable(dac_ff[3]))
    else $error("output register changed with load strobe high");

  a_clear_zero: assert property (
    !clear_all_n_i |-> in_ff[0] == `QDAC_ZERO_CODE
      && in_ff[1] == `QDAC_ZERO_CODE && in_ff[2] == `QDAC_ZERO_CODE
      && in_ff[3] == `QDAC_ZERO_CODE && dac_ff[0] == `QDAC_ZERO_CODE
      && dac_ff[1] == `QDAC_ZERO_CODE && dac_ff[2] == `QDAC_ZERO_CODE
      && dac_ff[3] == `QDAC_ZERO_CODE)
    else $error("registers not zero while clear held");

  a_clear_keeps_sr: assert property (
    !clear_all_n_i && !$past(sclk_rise) |-> $stable(sr_ff))
    else $error("clear disturbed the shift register");

  a_float_open: assert property (
    float_s |-> ##2 chan_open_o == 4'hF)
    else $error("floating data pin did not open all outputs");

  a_pd_keeps_code: assert property (
    $changed(hw_pd_ff) && $past(load_n_s) && clear_all_n_i
      |-> $stable(dac_ff[0]) && $stable(dac_ff[3]))
    else $error("entering or leaving shutdown altered a stored code");

  a_stop_all: assert property (
    pop && !pop_sac_n |=> sw_sd_ff == 4'hF)
    else $error("all-channel stop bit did not stop every channel");

  sequence s_sel_stop_pop;
    pop && pop_sac_n && !pop_sdc_n;
  endsequence

  sequence s_wake_pop;
    pop && pop_sac_n && pop_sdc_n;
  endsequence

  a_sel_stop: assert property (
    s_sel_stop_pop |=> sw_sd_ff[$past(pop_chan)])
    else $error("selected stop bit did not stop the addressed channel");

  a_wake_sel: assert property (
    s_wake_pop |=> !sw_sd_ff[$past(pop_chan)])
    else $error("word with both stop bits high did not wake its channel");

  a_float_flags: assert property (
    float_s |=> hw_pd_ff)
    else $error("floating data pin did not raise hardware shutdown");

  // a pop in the same cycle may legally stop a channel, so it is excluded
  a_float_release: assert property (
    !float_s && !pop && sw_sd_ff == 4'h0 |-> ##2 chan_open_o == 4'h0)
    else $error("outputs stayed open without any shutdown request");
endmodule

// ---- tb/qdac_host.sv ----
// serial host model for the converter's three-wire port
`timescale 1ns/1ps
module qdac_host
(
  input  wire logic ref_clk_i,
  output logic      serial_clk_o,
  output logic      chip_sel_n_o,
  output logic      data_o,
  output logic      float_o
);
  initial
  begin
    serial_clk_o = 1'b0;
    chip_sel_n_o = 1'b1;
    data_o       = 1'b0;
    float_o      = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // 400 ns serial clock, standing low outside frames
  task automatic send(input logic [15:0] w, input int n);
    chip_sel_n_o <= 1'b0;
    tick(4);
    for (int i = n - 1; i >= 0; i--)
    begin
      data_o <= w[i];
      tick(4);
      serial_clk_o <= 1'b1;
      tick(4);
      serial_clk_o <= 1'b0;
    end
    tick(4);
    chip_sel_n_o <= 1'b1;
    // a deselected pin must not look like a held bit
    data_o <= ~data_o;
    tick(12);
  endtask

  // three-stating the data pin
  task automatic set_float(input logic v);
    float_o <= v;
    tick(8);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the quad converter load logic
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end
module testbench;
  logic        clk;
  logic        rst;
  logic        load_n;
  logic        clr_n;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        flt;
  logic [7:0]  ch [4];
  logic [3:0]  chan_open;
  logic        hw_pd;
  logic        ready;
  int          errors;
  int          num_checks;

  qdac_host i_host (
    .ref_clk_i    (clk),
    .serial_clk_o (sclk),
    .chip_sel_n_o (cs_n),
    .data_o       (sdi),
    .float_o      (flt)
  );

  // depth 4 keeps the overflow run short
  qdac_top #(.FIFO_DEPTH(4)) i_dut (
    .ref_clk_i                (clk),
    .rst_i                    (rst),
    .serial_clk_i             (sclk),
    .chip_sel_n_i             (cs_n),
    .serial_in_or_float_off_i (sdi),
    .serial_in_float_i        (flt),
    .load_outputs_n_i         (load_n),
    .clear_all_n_i            (clr_n),
    .channel_output_first_o   (ch[0]),
    .channel_output_second_o  (ch[1]),
    .channel_output_third_o   (ch[2]),
    .channel_output_fourth_o  (ch[3]),
    .chan_open_o              (chan_open),
    .hw_power_down_o          (hw_pd),
    .word_ready_o             (ready)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_codes(input logic [31:0] exp);
    `CHK("codes", exp, {ch[3], ch[2], ch[1], ch[0]})
  endtask

  task automatic chk_state(input logic [3:0] op, input logic hw);
    `CHK("chan_open", op, chan_open)
    `CHK("hw_power_down", hw, hw_pd)
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    rst    = 1'b1;
    load_n = 1'b1;
    clr_n  = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_codes(32'h0);
    chk_state(4'h0, 1'b0);
    `CHK("ready", 1'b1, ready)
    $display("test reset done");

    load_n <= 1'b0;
    for (int c = 0; c < 4; c++)
      i_host.send({6'h03, c[1:0], 8'h1A + c[7:0]}, 12);
    chk_codes(32'h1D1C1B1A);
    $display("test channel load done");

    // four junk bits lead the word; only the last twelve count
    load_n <= 1'b1;
    i_host.send(16'h5DB7, 16);
    chk_codes(32'h1D1C1B1A);
    load_n <= 1'b0;
    repeat (6) @(posedge clk);
    load_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_codes(32'h1D1CB71A);
    $display("test load strobe done");

    clr_n <= 1'b0;
    @(posedge clk);
    chk_codes(32'h0);
    clr_n  <= 1'b1;
    load_n <= 1'b0;
    // a 4-bit frame joins the kept shift contents: word B7A
    i_host.send(16'h000A, 4);
    chk_codes(32'h7A000000);
    chk_state(4'h8, 1'b0);
    $display("test clear done");

    i_host.send(16'h0455, 12);
    chk_codes(32'h7A000055);
    chk_state(4'hF, 1'b0);
    for (int c = 0; c < 4; c++)
      i_host.send({6'h03, c[1:0], 8'h60 + c[7:0]}, 12);
    chk_state(4'h0, 1'b0);
    $display("test software stop done");

    // strobe high, so shutdown is seen against latched codes
    load_n <= 1'b1;
    i_host.set_float(1'b1);
    chk_state(4'hF, 1'b1);
    chk_codes(32'h63626160);
    i_host.set_float(1'b0);
    chk_state(4'h0, 1'b0);
    chk_codes(32'h63626160);
    $display("test hardware shutdown done");

    // fifo holds while cleared, so the fifth word finds it full
    clr_n  <= 1'b0;
    load_n <= 1'b0;
    for (int k = 1; k <= 5; k++)
      i_host.send({8'h0C, k[7:0]}, 12);
    `CHK("ready", 1'b0, ready)
    clr_n <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("ready", 1'b1, ready)
    chk_codes(32'h00000004);
    $display("test fifo overflow done");
    tally_and_finish();
  end
endmodule
